// ---- hw/ext_io_pkg.sv ----
/*
 * Constants and types shared by the external control port and its helpers.
 * Assumes a 25 MHz system clock.
 */
package ext_io_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned SAMPLE_PERIOD_MS = 10;
    localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
    localparam int unsigned TICK_W = 18;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);
    localparam int unsigned N_CTRL = 9;
    // control input bit positions
    localparam int unsigned IN_OFF = 0;
    localparam int unsigned IN_ON = 1;
    localparam int unsigned IN_START = 2;
    localparam int unsigned IN_STOP = 3;
    localparam int unsigned IN_HOLD = 4;
    localparam int unsigned IN_BR1 = 5;
    localparam int unsigned IN_BR2 = 6;
    localparam int unsigned IN_RECALL = 7;
    localparam int unsigned IN_CLEAR = 8;
    // inputs idle high through pull-ups
    localparam logic [N_CTRL-1:0] CTRL_RESET = 9'h1ff;
    localparam logic POLARITY_NEG = 1'b0;
    // marked lines at their inactive level under negative polarity
    localparam logic [6:0] STATE_RESET = 7'h7c;
    localparam logic [2:0] SLOT_RESET = 3'h1;
    typedef enum logic [1:0] {
        MODE_CONT,
        MODE_SEQ,
        MODE_SIM
    } op_mode_t;
    typedef enum logic [1:0] {
        MEM_SETTING,
        MEM_SEQUENCE,
        MEM_SIMULATION
    } mem_kind_t;
endpackage : ext_io_pkg

// ---- hw/sample_if.sv ----
/*
 * Carries the 10 ms sample tick and detected falling edges between modules.
 * Assumes a single clock domain.
 */
`timescale 1ns/1ns
interface sample_if;
    import ext_io_pkg::*;
    logic tick;
    logic [N_CTRL-1:0] fall;
    modport src (output tick, output fall);
    modport dst (input tick, input fall);
endinterface : sample_if

// ---- hw/sample_tick.sv ----
/*
 * Sample period timer and falling-edge detector for the control inputs.
 * Assumes inputs synchronous to clk_i.
 */
`timescale 1ns/1ns
module sample_tick
    import ext_io_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SAMPLE_CYCLES
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [N_CTRL-1:0] ctrl_i,
    sample_if.src s
);
    logic [TICK_W-1:0] cnt_reg;
    logic [TICK_W-1:0] cnt_next;
    logic [N_CTRL-1:0] last_reg;
    logic [N_CTRL-1:0] last_next;
    logic tick;
    logic primed_reg;
    logic primed_next;
    // only a bench shortens the period; hardware keeps the 10 ms default
    localparam logic [TICK_W-1:0] TICK_END = TICK_W'(TICK_CYCLES - 1);

    always_comb begin
        tick = (cnt_reg == TICK_END);
        cnt_next = tick ? '0 : cnt_reg + TICK_W'(1);
        last_next = tick ? ctrl_i : last_reg;
        primed_next = primed_reg | tick;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
            last_reg <= CTRL_RESET;
            primed_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            last_reg <= last_next;
            primed_reg <= primed_next;
        end
    end

    assign s.tick = tick;
    genvar g;
    generate
        for (g = 0; g < N_CTRL; g++) begin : g_edge
            // no edge before a real high sample, so a line held low over reset stays quiet
            assign s.fall[g] = tick & primed_reg & last_reg[g] & ~ctrl_i[g];
        end
    endgenerate

    property p_tick_period;
        @(posedge clk_i) disable iff (!reset_n_i)
        tick |=> !tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick repeated too soon");
endmodule : sample_tick

// ---- hw/status_drive.sv ----
/*
 * Registered state outputs with collective polarity on the marked lines.
 * Assumes updates only when the sample tick is high.
 */
`timescale 1ns/1ns
module status_drive
    import ext_io_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    sample_if.dst s,
    input wire logic polarity_pos_i,
    input wire logic power_on_i,
    input wire logic range_100v_i,
    input wire logic out_on_i,
    input wire logic prot_i,
    input wire logic limit_i,
    input wire logic agc_on_i,
    input wire logic busy_i,
    output logic [6:0] state_o
);
    logic [6:0] st_reg;
    logic [6:0] st_next;
    logic inv;

    always_comb begin
        inv = (polarity_pos_i == POLARITY_NEG);
        st_next = st_reg;
        if (s.tick) begin
            st_next[0] = power_on_i;
            st_next[1] = range_100v_i;
            st_next[2] = out_on_i ^ inv;
            st_next[3] = prot_i ^ inv;
            st_next[4] = limit_i ^ inv;
            st_next[5] = agc_on_i ^ inv;
            st_next[6] = busy_i ^ inv;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign state_o = st_reg;

    property p_power_line;
        @(posedge clk_i) disable iff (!reset_n_i)
        s.tick |=> state_o[0] == $past(power_on_i);
    endproperty
    a_power_line: assert property (p_power_line) else $error("power line wrong");

    property p_prot_pol;
        @(posedge clk_i) disable iff (!reset_n_i)
        s.tick |=> state_o[3] == ($past(prot_i) ^ ($past(polarity_pos_i) == 1'b0));
    endproperty
    a_prot_pol: assert property (p_prot_pol) else $error("protection polarity wrong");
endmodule : status_drive

// ---- hw/ext_control_io.sv ----
/*
 * External control port: sampled falling-edge commands, recall selection,
 * protection shutdown and state outputs.
 * Assumes inputs synchronous to clk_i and the rest of the unit acting on pulses.
 */
`timescale 1ns/1ns
module ext_control_io
    import ext_io_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SAMPLE_CYCLES
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [N_CTRL-1:0] ctrl_i,
    input wire logic [1:0] mem_sel_i,
    input wire logic ext_enable_i,
    input wire logic remote_i,
    input wire logic polarity_pos_i,
    input wire logic [1:0] op_mode_i,
    input wire logic [1:0] step_level_i,
    input wire logic self_test_done_i,
    input wire logic self_test_ok_i,
    input wire logic over_vi_i,
    input wire logic unit_fault_i,
    input wire logic internal_fault_i,
    input wire logic range_100v_i,
    input wire logic prot_i,
    input wire logic limit_i,
    input wire logic agc_on_i,
    input wire logic busy_i,
    output logic out_on_o,
    output logic display_on_o,
    output logic halted_o,
    output logic ready_o,
    output logic seq_start_o,
    output logic seq_stop_o,
    output logic seq_hold_o,
    output logic branch1_o,
    output logic branch2_o,
    output logic peak_clear_o,
    output logic recall_o,
    output logic [2:0] recall_slot_o,
    output logic [1:0] recall_kind_o,
    output logic recall_compile_o,
    output logic [1:0] step_sync_o,
    output logic [6:0] state_o
);
    sample_if smp();

    logic out_on_reg, out_on_next;
    logic disp_reg, disp_next;
    logic halt_reg, halt_next;
    logic ready_reg, ready_next;
    logic [5:0] pulse_reg, pulse_next;
    logic recall_reg, recall_next;
    logic [2:0] slot_reg, slot_next;
    logic [1:0] kind_reg, kind_next;
    logic comp_reg, comp_next;
    logic [1:0] sync_reg, sync_next;
    logic accept;
    logic fault;
    logic [N_CTRL-1:0] f;

    function automatic logic [1:0] mem_for_mode(input logic [1:0] m);
        logic [1:0] k;
        k = MEM_SETTING;
        case (m)
            MODE_SEQ: k = MEM_SEQUENCE;
            MODE_SIM: k = MEM_SIMULATION;
            default: k = MEM_SETTING;
        endcase
        return k;
    endfunction : mem_for_mode

    sample_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ctrl_i(ctrl_i),
        .s(smp.src)
    );

    status_drive u_status (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .s(smp.dst),
        .polarity_pos_i(polarity_pos_i),
        .power_on_i(1'b1),
        .range_100v_i(range_100v_i),
        .out_on_i(out_on_reg),
        .prot_i(prot_i),
        .limit_i(limit_i),
        .agc_on_i(agc_on_i),
        .busy_i(busy_i),
        .state_o(state_o)
    );

    always_comb begin
        accept = ext_enable_i & ~remote_i & ready_reg & ~halt_reg;
        f = accept ? smp.fall : '0;
        fault = over_vi_i | unit_fault_i | internal_fault_i;
    end

    always_comb begin
        ready_next = ready_reg;
        halt_next = halt_reg;
        out_on_next = out_on_reg;
        disp_next = disp_reg;
        // leave start-up only on good checks
        if (!ready_reg && self_test_done_i && self_test_ok_i) begin
            ready_next = 1'b1;
            disp_next = 1'b1;
        end
        if (f[IN_ON]) begin
            out_on_next = 1'b1;
        end
        if (f[IN_OFF]) begin
            out_on_next = 1'b0;
        end
        if (fault) begin
            out_on_next = 1'b0;
            disp_next = 1'b0;
        end
        if (internal_fault_i) begin
            halt_next = 1'b1;
        end
        if (!ready_reg) begin
            out_on_next = 1'b0;
        end
    end

    always_comb begin
        // sequence commands in seq or sim mode
        pulse_next = '0;
        if (op_mode_i == MODE_SEQ || op_mode_i == MODE_SIM) begin
            pulse_next[0] = f[IN_START];
            pulse_next[1] = f[IN_STOP];
            pulse_next[2] = f[IN_HOLD];
            pulse_next[3] = f[IN_BR1];
            pulse_next[4] = f[IN_BR2];
        end
        pulse_next[5] = f[IN_CLEAR];
        recall_next = f[IN_RECALL];
        slot_next = slot_reg;
        kind_next = kind_reg;
        comp_next = comp_reg;
        if (f[IN_RECALL]) begin
            slot_next = {1'b0, mem_sel_i} + 3'h1;
            kind_next = mem_for_mode(op_mode_i);
            comp_next = (op_mode_i != MODE_CONT);
        end
        // step sync in seq and sim
        sync_next = sync_reg;
        if (smp.tick && (op_mode_i == MODE_SEQ || op_mode_i == MODE_SIM)) begin
            sync_next = step_level_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_on_reg <= 1'b0;
            disp_reg <= 1'b0;
            halt_reg <= 1'b0;
            ready_reg <= 1'b0;
            pulse_reg <= '0;
            recall_reg <= 1'b0;
            slot_reg <= SLOT_RESET;
            kind_reg <= MEM_SETTING;
            comp_reg <= 1'b0;
            sync_reg <= '0;
        end else begin
            out_on_reg <= out_on_next;
            disp_reg <= disp_next;
            halt_reg <= halt_next;
            ready_reg <= ready_next;
            pulse_reg <= pulse_next;
            recall_reg <= recall_next;
            slot_reg <= slot_next;
            kind_reg <= kind_next;
            comp_reg <= comp_next;
            sync_reg <= sync_next;
        end
    end

    assign out_on_o = out_on_reg;
    assign display_on_o = disp_reg;
    assign halted_o = halt_reg;
    assign ready_o = ready_reg;
    assign seq_start_o = pulse_reg[0];
    assign seq_stop_o = pulse_reg[1];
    assign seq_hold_o = pulse_reg[2];
    assign branch1_o = pulse_reg[3];
    assign branch2_o = pulse_reg[4];
    assign peak_clear_o = pulse_reg[5];
    assign recall_o = recall_reg;
    assign recall_slot_o = slot_reg;
    assign recall_kind_o = kind_reg;
    assign recall_compile_o = comp_reg;
    assign step_sync_o = sync_reg;

    property p_disabled_quiet;
        @(posedge clk_i) disable iff (!reset_n_i)
        !ext_enable_i |=> !recall_o && !peak_clear_o && !seq_start_o;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("action while disabled");

    property p_remote_quiet;
        @(posedge clk_i) disable iff (!reset_n_i)
        remote_i |=> !recall_o && !seq_stop_o && !branch1_o;
    endproperty
    a_remote_quiet: assert property (p_remote_quiet) else $error("action in remote");

    property p_off_edge;
        @(posedge clk_i) disable iff (!reset_n_i)
        smp.fall[IN_OFF] && accept |=> !out_on_o;
    endproperty
    a_off_edge: assert property (p_off_edge) else $error("output not off");

    property p_start_edge;
        @(posedge clk_i) disable iff (!reset_n_i)
        smp.fall[IN_START] && accept && op_mode_i == MODE_SIM |=> seq_start_o;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start missing in sim");

    property p_slot;
        @(posedge clk_i) disable iff (!reset_n_i)
        smp.fall[IN_RECALL] && accept |=> recall_o && recall_slot_o == {1'b0, $past(mem_sel_i)} + 3'h1;
    endproperty
    a_slot: assert property (p_slot) else $error("wrong recall slot");

    property p_kind;
        @(posedge clk_i) disable iff (!reset_n_i)
        recall_o |-> recall_compile_o == (recall_kind_o != MEM_SETTING);
    endproperty
    a_kind: assert property (p_kind) else $error("compile flag mismatch");

    property p_fault_off;
        @(posedge clk_i) disable iff (!reset_n_i)
        over_vi_i || unit_fault_i |=> !out_on_o && !display_on_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault did not shut down");

    property p_halt;
        @(posedge clk_i) disable iff (!reset_n_i)
        internal_fault_i |=> halted_o ##1 (halted_o && !out_on_o) [*8];
    endproperty
    a_halt: assert property (p_halt) else $error("halt not held");

    property p_not_ready;
        @(posedge clk_i) disable iff (!reset_n_i)
        !ready_o |-> !out_on_o;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("output on before checks");

    property p_on_edge;
        @(posedge clk_i) disable iff (!reset_n_i)
        smp.fall[IN_ON] && !smp.fall[IN_OFF] && accept && !fault |=> out_on_o;
    endproperty
    a_on_edge: assert property (p_on_edge) else $error("output not on");

    property p_hold_edge;
        @(posedge clk_i) disable iff (!reset_n_i)
        smp.fall[IN_HOLD] && accept && op_mode_i == MODE_SEQ |=> seq_hold_o;
    endproperty
    a_hold_edge: assert property (p_hold_edge) else $error("hold missing in sequence");

    property p_cont_quiet;
        @(posedge clk_i) disable iff (!reset_n_i)
        op_mode_i == MODE_CONT |=> !seq_start_o && !seq_stop_o && !seq_hold_o && !branch1_o && !branch2_o;
    endproperty
    a_cont_quiet: assert property (p_cont_quiet) else $error("sequence command in continuous");

    property p_step_sync;
        @(posedge clk_i) disable iff (!reset_n_i)
        smp.tick && (op_mode_i == MODE_SEQ || op_mode_i == MODE_SIM) |=> step_sync_o == $past(step_level_i);
    endproperty
    a_step_sync: assert property (p_step_sync) else $error("step sync level wrong");

    property p_unit_display;
        @(posedge clk_i) disable iff (!reset_n_i)
        unit_fault_i |=> !display_on_o [*2];
    endproperty
    a_unit_display: assert property (p_unit_display) else $error("display on after unit fault");

    property p_pulse_once;
        @(posedge clk_i) disable iff (!reset_n_i)
        recall_o || peak_clear_o |=> !recall_o && !peak_clear_o;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("command pulse repeated");
endmodule : ext_control_io

// ---- testbench/ext_controller.sv ----
/*
 * Model of the external controller: drives the control lines and the
 * memory select of the external control port.
 * Assumes the bench calls apply() at most once per sample period.
 */
`timescale 1ns/1ns
module ext_controller
    import ext_io_pkg::*;
(
    input wire logic clk_i,
    output logic [N_CTRL-1:0] ctrl_o,
    output logic [1:0] mem_sel_o
);
    initial begin
        // released lines sit high through the pull-ups
        ctrl_o = CTRL_RESET;
        mem_sel_o = 2'h0;
    end

    // levels held until the next call
    task automatic apply(input logic [N_CTRL-1:0] c, input logic [1:0] sel);
        @(posedge clk_i);
        #2;
        ctrl_o = c;
        mem_sel_o = sel;
    endtask : apply
endmodule : ext_controller

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench for the external control port.
 * Assumes a 16-cycle sample period set through TICK_CYCLES to keep the run short.
 */
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("BAD %0t got %h exp %h", $time, got, exp); \
    end \
end
module testbench;
    import ext_io_pkg::*;
    typedef struct packed {
        logic [8:0] c;
        logic [1:0] sel;
        logic [1:0] mode;
        logic pol;
        logic [6:0] ep;
        logic eon;
    } row_t;
    localparam logic [8:0] ALL = 9'h1ff;
    localparam int TB_TICK = 16;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [8:0] ctrl;
    logic [1:0] sel;
    logic ext_enable_i = 1'b1, remote_i = 1'b0, polarity_pos_i = 1'b0;
    logic [1:0] op_mode_i = 2'h0, step_level_i = 2'h0;
    logic self_test_done_i = 1'b1, self_test_ok_i = 1'b0;
    logic over_vi_i = 1'b0, unit_fault_i = 1'b0, internal_fault_i = 1'b0;
    logic range_100v_i = 1'b0, prot_i = 1'b0, limit_i = 1'b0, agc_on_i = 1'b0, busy_i = 1'b0;
    logic out_on_o, display_on_o, halted_o, ready_o, recall_o, recall_compile_o, prev_on = 1'b0;
    logic seq_start_o, seq_stop_o, seq_hold_o, branch1_o, branch2_o, peak_clear_o;
    logic [2:0] recall_slot_o;
    logic [1:0] recall_kind_o, step_sync_o;
    logic [6:0] state_o, pulses;
    int num_errors = 0, n_compared = 0, cycles = 0;
    row_t rows [10];

    assign pulses = {seq_start_o, seq_stop_o, seq_hold_o, branch1_o, branch2_o, peak_clear_o, recall_o};
    always #20 clk_i = ~clk_i;

    ext_controller u_ext_controller (.clk_i(clk_i), .ctrl_o(ctrl), .mem_sel_o(sel));
    ext_control_io #(.TICK_CYCLES(TB_TICK)) u_ext_control_io (.clk_i(clk_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl),
        .mem_sel_i(sel), .ext_enable_i(ext_enable_i), .remote_i(remote_i), .polarity_pos_i(polarity_pos_i),
        .op_mode_i(op_mode_i), .step_level_i(step_level_i), .self_test_done_i(self_test_done_i),
        .self_test_ok_i(self_test_ok_i), .over_vi_i(over_vi_i), .unit_fault_i(unit_fault_i),
        .internal_fault_i(internal_fault_i), .range_100v_i(range_100v_i), .prot_i(prot_i),
        .limit_i(limit_i), .agc_on_i(agc_on_i), .busy_i(busy_i), .out_on_o(out_on_o),
        .display_on_o(display_on_o), .halted_o(halted_o), .ready_o(ready_o), .seq_start_o(seq_start_o),
        .seq_stop_o(seq_stop_o), .seq_hold_o(seq_hold_o), .branch1_o(branch1_o), .branch2_o(branch2_o),
        .peak_clear_o(peak_clear_o), .recall_o(recall_o), .recall_slot_o(recall_slot_o),
        .recall_kind_o(recall_kind_o), .recall_compile_o(recall_compile_o), .step_sync_o(step_sync_o),
        .state_o(state_o));

    function automatic logic [8:0] low(input int k);
        return ALL & ~(9'h001 << k);
    endfunction : low

    // marked lines invert under negative polarity, power and range never do
    function automatic logic [6:0] exp_state(input logic on);
        logic [4:0] m;
        m = {busy_i, agc_on_i, limit_i, prot_i, on};
        if (!polarity_pos_i) m = ~m;
        return {m, range_100v_i, 1'b1};
    endfunction : exp_state

    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // range toggles every step so its change on state_o marks the tick
    task automatic step(input logic [8:0] c, input logic [1:0] s, input logic [6:0] ep, input logic eon);
        logic [6:0] seen;
        int n;
        seen = 7'h00;
        n = 0;
        u_ext_controller.apply(c, s);
        range_100v_i = ~range_100v_i;
        while (state_o[1] !== range_100v_i && n < 4 * TB_TICK) begin
            @(posedge clk_i);
            #2;
            seen = seen | pulses;
            n++;
        end
        // state sampled at the tick still shows the output level from before it
        `CHECK(state_o, exp_state(prev_on))
        `CHECK(seen, ep)
        `CHECK(out_on_o, eon)
        if (op_mode_i != 2'h0) `CHECK(step_sync_o, step_level_i)
        prev_on = eon;
    endtask : step

    task automatic do_reset(input logic rdy);
        @(posedge clk_i);
        #2;
        reset_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        `CHECK({out_on_o, display_on_o, halted_o, ready_o, pulses, recall_slot_o, state_o, step_sync_o},
               {4'h0, 7'h00, 3'h1, 7'h7c, 2'h0})
        #2;
        reset_n_i = 1'b1;
        prev_on = 1'b0;
        repeat (3) @(posedge clk_i);
        #2;
        `CHECK({ready_o, display_on_o}, {rdy, rdy})
    endtask : do_reset

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            $display("BAD %0t run did not finish", $time);
            end_of_test();
        end
    end

    initial begin
        do_reset(1'b0);
        step(low(IN_ON), 2'h0, 7'h00, 1'b0);
        self_test_ok_i = 1'b1;
        step(ALL, 2'h0, 7'h00, 1'b0);
        `CHECK({ready_o, display_on_o}, 2'h3)
        rows = '{'{low(IN_ON), 2'h0, 2'h1, 1'b0, 7'h00, 1'b1},
                 '{low(IN_START), 2'h0, 2'h1, 1'b1, 7'h40, 1'b1},
                 '{low(IN_STOP), 2'h0, 2'h1, 1'b1, 7'h20, 1'b1},
                 '{low(IN_HOLD), 2'h0, 2'h1, 1'b0, 7'h10, 1'b1},
                 '{low(IN_BR1), 2'h0, 2'h1, 1'b1, 7'h08, 1'b1},
                 '{low(IN_BR2), 2'h0, 2'h1, 1'b0, 7'h04, 1'b1},
                 '{low(IN_CLEAR), 2'h0, 2'h1, 1'b1, 7'h02, 1'b1},
                 '{low(IN_RECALL), 2'h2, 2'h1, 1'b0, 7'h01, 1'b1},
                 '{low(IN_OFF), 2'h0, 2'h1, 1'b1, 7'h00, 1'b0},
                 '{low(IN_OFF), 2'h0, 2'h1, 1'b0, 7'h00, 1'b0}};
        foreach (rows[i]) begin
            op_mode_i = rows[i].mode;
            polarity_pos_i = rows[i].pol;
            {busy_i, agc_on_i, limit_i, prot_i} = 4'(i + 5);
            step_level_i = 2'(i);
            step(rows[i].c, rows[i].sel, rows[i].ep, rows[i].eon);
        end
        `CHECK({recall_slot_o, recall_kind_o, recall_compile_o}, {3'h3, 2'h1, 1'b1})
        op_mode_i = 2'h0;
        step(low(IN_START) & low(IN_RECALL), 2'h0, 7'h01, 1'b0);
        `CHECK({recall_slot_o, recall_kind_o, recall_compile_o}, {3'h1, 2'h0, 1'b0})
        step(ALL, 2'h3, 7'h00, 1'b0);
        op_mode_i = 2'h2;
        step(low(IN_START) & low(IN_RECALL), 2'h3, 7'h41, 1'b0);
        `CHECK({recall_slot_o, recall_kind_o, recall_compile_o}, {3'h4, 2'h2, 1'b1})
        ext_enable_i = 1'b0;
        step(low(IN_ON), 2'h0, 7'h00, 1'b0);
        ext_enable_i = 1'b1;
        remote_i = 1'b1;
        step(ALL, 2'h0, 7'h00, 1'b0);
        step(low(IN_ON), 2'h0, 7'h00, 1'b0);
        remote_i = 1'b0;
        step(ALL, 2'h0, 7'h00, 1'b0);
        step(low(IN_ON), 2'h0, 7'h00, 1'b1);
        over_vi_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #2;
        `CHECK({out_on_o, display_on_o}, 2'h0)
        over_vi_i = 1'b0;
        do_reset(1'b1);
        step(low(IN_ON), 2'h0, 7'h00, 1'b0);
        unit_fault_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #2;
        `CHECK({out_on_o, display_on_o}, 2'h0)
        unit_fault_i = 1'b0;
        do_reset(1'b1);
        internal_fault_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #2;
        `CHECK({out_on_o, display_on_o, halted_o}, 3'h1)
        internal_fault_i = 1'b0;
        u_ext_controller.apply(ALL, 2'h0);
        repeat (TB_TICK + 4) @(posedge clk_i);
        u_ext_controller.apply(low(IN_ON), 2'h0);
        repeat (TB_TICK + 4) @(posedge clk_i);
        #2;
        `CHECK({out_on_o, halted_o}, 2'h1)
        end_of_test();
    end
endmodule : testbench
